// ### pkg/apm_pkg.sv
// Purpose: constants for the analog point poll manager
// Assumes: 125 MHz clock, point identifiers are plain indices
// Notes: long second-scale counts are top-level parameters
// How it works
// R1: accept one request of up to ten current-loop points as active set.
// R2: request over ten points gets an exception, acquisition untouched.
// R3: request naming any non current-loop point gets an exception.
// R4: first response to a new set returns zero for every point; the code returns kept values for points carried over from the old set (R11).
// R5: acquire active points every five seconds, values refresh no faster.
// R6: client waits five seconds after initialization before polling again.
// R7: fetch only points in alarm, return zero for normal points.
// R8: point returning to normal stops fetching and clears its value.
// R9: stop acquiring when no matching request within idle timeout, 20 s default.
// R10: a different set gets initialization zeros, then five-second acquisition.
// R11: overlap keeps values of kept points, zeros new ones, drops others.
// R12: acquire only points named in the latest accepted request.
// R13: an exactly matching request restarts the idle timeout.
package apm_pkg;
	// ==========================================
	// sizes
	localparam int APM_MAX_POINTS = 10;
	localparam int APM_ID_W = 16;
	localparam int APM_VAL_W = 16;
	localparam int APM_CNT_W = 4;
	localparam int APM_TMR_W = 32;
	localparam logic [APM_VAL_W-1:0] APM_ZERO_VAL = 16'h0000;
	// ==========================================
	// timing
	localparam int APM_CLK_MHZ = 125;
	localparam int APM_REFRESH_S = 5;
	localparam int APM_IDLE_S = 20;
	localparam longint APM_REFRESH_CYC = longint'(APM_REFRESH_S) * APM_CLK_MHZ * 1000000;
	localparam longint APM_IDLE_CYC = longint'(APM_IDLE_S) * APM_CLK_MHZ * 1000000;
	// ==========================================
	// answer codes
	localparam logic [1:0] APM_RSP_VALUES = 2'h0;
	localparam logic [1:0] APM_RSP_INIT = 2'h1;
	localparam logic [1:0] APM_RSP_EXC_COUNT = 2'h2;
	localparam logic [1:0] APM_RSP_EXC_TYPE = 2'h3;
endpackage : apm_pkg

// ### rtl/apm_poll_manager.sv
// Purpose: tracks the active analog set, answers polls, drives panel fetches
// Assumes: request list presented flat with per-slot point type and alarm flags
// Notes: one fetch in flight at a time; fetch_ready from the panel side
`timescale 1ns/1ps
module apm_poll_manager #(
	parameter longint REFRESH_CYC = apm_pkg::APM_REFRESH_CYC,
	parameter longint IDLE_CYC = apm_pkg::APM_IDLE_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire logic [apm_pkg::APM_CNT_W:0] req_count,
	input wire logic [apm_pkg::APM_MAX_POINTS*apm_pkg::APM_ID_W-1:0] req_ids,
	input wire logic [apm_pkg::APM_MAX_POINTS-1:0] req_is_loop,
	input wire logic [apm_pkg::APM_MAX_POINTS-1:0] point_alarm,
	output logic rsp_valid,
	output logic [1:0] rsp_code,
	output logic [apm_pkg::APM_MAX_POINTS*apm_pkg::APM_VAL_W-1:0] rsp_values,
	output logic fetch_valid,
	output logic [apm_pkg::APM_ID_W-1:0] fetch_id,
	input wire logic fetch_ready,
	input wire logic fetch_done,
	input wire logic [apm_pkg::APM_VAL_W-1:0] fetch_value,
	output logic active,
	output logic [apm_pkg::APM_MAX_POINTS-1:0] slot_used
);
	import apm_pkg::*;
	localparam int N = APM_MAX_POINTS;
	typedef enum logic [1:0] {APM_IDLE, APM_ISSUE, APM_WAIT} apm_state_t;

	logic [APM_ID_W-1:0] id_reg [N], id_next [N];
	logic [APM_VAL_W-1:0] val_reg [N], val_next [N];
	logic [N-1:0] used_reg, used_next;
	logic act_reg, act_next;
	logic [APM_TMR_W-1:0] idle_reg, idle_next, ref_reg, ref_next;
	logic [APM_CNT_W-1:0] scan_reg, scan_next;
	apm_state_t st_reg, st_next;
	logic rv_reg, rv_next;
	logic [1:0] rc_reg, rc_next;
	logic [N*APM_VAL_W-1:0] rd_reg, rd_next;
	logic [N-1:0] req_used, bad_type, old_hit, slot_diff;
	logic same_set;
	logic [APM_VAL_W-1:0] keep_val [N];
	logic [APM_ID_W-1:0] fid_reg, fid_next;

	// ==========================================
	// request decode: one copy per slot of usage, type check and overlap lookup
	for (genvar gi = 0; gi < N; gi++) begin : g_slot
		logic [APM_ID_W-1:0] new_id;
		logic hit;
		logic [APM_VAL_W-1:0] kv;
		assign new_id = req_ids[gi*APM_ID_W +: APM_ID_W];
		assign req_used[gi] = (APM_CNT_W+1)'(gi) < req_count;
		assign bad_type[gi] = req_used[gi] && !req_is_loop[gi]; // R3
		// a slot differs when its use or its stored id changes
		assign slot_diff[gi] = (req_used[gi] != used_reg[gi]) || (req_used[gi] && id_reg[gi] != new_id);
		// search every stored slot, a kept point may sit at another position
		always_comb begin
			hit = 1'b0;
			kv = APM_ZERO_VAL;
			for (int j = 0; j < N; j++) begin
				if (used_reg[j] && id_reg[j] == new_id) begin
					hit = 1'b1;
					kv = val_reg[j]; // R11
				end
			end
		end
		assign old_hit[gi] = hit;
		assign keep_val[gi] = kv;
	end

	// only an active set can be matched exactly
	assign same_set = act_reg && !(|slot_diff);

	// ==========================================
	// set tracking, answers, timers and fetch sequencer
	always_comb begin
		id_next = id_reg;
		val_next = val_reg;
		used_next = used_reg;
		act_next = act_reg;
		idle_next = idle_reg;
		ref_next = ref_reg;
		scan_next = scan_reg;
		st_next = st_reg;
		rv_next = 1'b0;
		rc_next = rc_reg;
		rd_next = rd_reg;

		// sequencer: one pass over the set per refresh period
		// the pass start and the refresh count never touch ref_next in one cycle
		unique case (st_reg)
			APM_IDLE: begin
				if (act_reg && ref_reg == APM_TMR_W'(REFRESH_CYC - 1)) begin
					ref_next = '0; // R5
					scan_next = '0;
					st_next = APM_ISSUE;
				end
			end
			APM_ISSUE: begin
				// a quiet or unused slot is zeroed in one cycle with no panel traffic
				if (!used_reg[scan_reg] || !point_alarm[scan_reg]) begin
					val_next[scan_reg] = APM_ZERO_VAL; // R7 R8
					if (scan_reg == APM_CNT_W'(N - 1)) begin
						st_next = APM_IDLE;
					end else begin
						scan_next = scan_reg + 1'b1;
					end
				end else if (fetch_ready) begin
					st_next = APM_WAIT; // R7
				end
			end
			APM_WAIT: begin
				// the alarm may drop while the fetch runs; the result is then discarded
				if (fetch_done) begin
					val_next[scan_reg] = point_alarm[scan_reg] ? fetch_value : APM_ZERO_VAL; // R8
					if (scan_reg == APM_CNT_W'(N - 1)) begin
						st_next = APM_IDLE;
					end else begin
						scan_next = scan_reg + 1'b1;
						st_next = APM_ISSUE;
					end
				end
			end
		endcase

		// timers run while a set is active; they come after the sequencer so that
		// an expiry parks the sequencer even in the middle of a pass
		if (act_reg) begin
			if (idle_reg == APM_TMR_W'(IDLE_CYC - 1)) begin
				act_next = 1'b0; // R9
				used_next = '0;
				st_next = APM_IDLE;
			end else begin
				idle_next = idle_reg + 1'b1;
			end
			if (ref_reg != APM_TMR_W'(REFRESH_CYC - 1)) begin
				ref_next = ref_reg + 1'b1;
			end
		end

		// an accepted request overrides the idle timer for this cycle, a new set the refresh timer too
		// refused requests leave the set, the timers and the stored values alone
		if (req_valid) begin
			rv_next = 1'b1;
			if (req_count > (APM_CNT_W+1)'(N) || req_count == '0) begin
				rc_next = APM_RSP_EXC_COUNT; // R2
			end else if (|bad_type) begin
				rc_next = APM_RSP_EXC_TYPE; // R3
			end else if (same_set) begin
				rc_next = APM_RSP_VALUES;
				used_next = used_reg; // a match on the expiry edge keeps the set
				idle_next = '0; // R13
				act_next = 1'b1;
				for (int i = 0; i < N; i++) begin
					rd_next[i*APM_VAL_W +: APM_VAL_W] = val_reg[i];
				end
			end else begin
				// new set: copy ids, carry over values of points already acquired
				rc_next = APM_RSP_INIT; // R4 R10
				act_next = 1'b1; // R1
				idle_next = '0;
				ref_next = '0;
				st_next = APM_IDLE; // in-flight fetch for the old set is abandoned
				used_next = req_used; // R12
				for (int i = 0; i < N; i++) begin
					id_next[i] = req_ids[i*APM_ID_W +: APM_ID_W];
					val_next[i] = req_used[i] ? keep_val[i] : APM_ZERO_VAL; // R11
					rd_next[i*APM_VAL_W +: APM_VAL_W] = (req_used[i] && old_hit[i]) ? keep_val[i] : APM_ZERO_VAL;
				end
			end
		end

		// fetch id flop tracks the slot that the sequencer will point at next
		fid_next = id_next[scan_next];
	end

	// ==========================================
	// state registers
	// every register loads its next value; reset clears the set and the answer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < N; i++) begin
				id_reg[i] <= '0;
				val_reg[i] <= APM_ZERO_VAL;
			end
			used_reg <= '0;
			act_reg <= 1'b0;
			idle_reg <= '0;
			ref_reg <= '0;
			scan_reg <= '0;
			st_reg <= APM_IDLE;
			rv_reg <= 1'b0;
			rc_reg <= APM_RSP_VALUES;
			rd_reg <= '0;
			fid_reg <= '0;
		end else begin
			id_reg <= id_next;
			val_reg <= val_next;
			used_reg <= used_next;
			act_reg <= act_next;
			idle_reg <= idle_next;
			ref_reg <= ref_next;
			scan_reg <= scan_next;
			st_reg <= st_next;
			rv_reg <= rv_next;
			rc_reg <= rc_next;
			rd_reg <= rd_next;
			fid_reg <= fid_next;
		end
	end

	// ==========================================
	// outputs
	// answer and data outputs come straight from flops
	assign rsp_valid = rv_reg;
	assign rsp_code = rc_reg;
	assign rsp_values = rd_reg;
	// fetch request drops at once when the point leaves alarm
	assign fetch_valid = (st_reg == APM_ISSUE) && used_reg[scan_reg] && point_alarm[scan_reg]; // R8
	assign fetch_id = fid_reg;
	assign active = act_reg;
	assign slot_used = used_reg;
endmodule // apm_poll_manager

// ### sim/apm_poll_monitor.sv
// Purpose: port checks of the poll manager
// Assumes: bound to each instance
// Notes: judges outputs only
`timescale 1ns/1ps
module apm_poll_monitor import apm_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire logic rsp_valid,
	input wire logic fetch_valid,
	input wire logic fetch_ready,
	input wire logic active,
	input wire logic [4:0] req_count,
	input wire logic [9:0] req_is_loop,
	input wire logic [9:0] slot_used,
	input wire logic [9:0] point_alarm,
	input wire logic [1:0] rsp_code,
	input wire logic [15:0] fetch_id
);
	// ====================
	// helpers: bad count, named slot of wrong type
	logic cnt_bad;
	logic [9:0] bad;
	assign cnt_bad = req_count == 5'h00 || req_count > 5'h0A;
	assign bad = ~req_is_loop & ((10'h001 << req_count) - 10'h001);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_stall;
		fetch_valid && !fetch_ready && !req_valid;
	endsequence
	// the fetch is still wanted: set alive and no alarm change
	sequence s_wanted;
		active && $stable(point_alarm);
	endsequence
	a_rsp_one_late: assert property (req_valid |=> rsp_valid) else $error("late");
	a_rsp_only_req: assert property (rsp_valid |-> $past(req_valid)) else $error("stray");
	a_count_exc: assert property (req_valid && cnt_bad |=> rsp_code == APM_RSP_EXC_COUNT) else $error("cnt");
	a_type_exc: assert property (req_valid && !cnt_bad && bad != 10'h000 |=> rsp_code == APM_RSP_EXC_TYPE) else $error("typ");
	a_init_act: assert property (rsp_valid && rsp_code == APM_RSP_INIT |-> active) else $error("init");
	a_fetch_act: assert property (fetch_valid |-> active) else $error("fetch");
	a_fetch_hold: assert property (s_stall ##1 s_wanted |-> fetch_valid && $stable(fetch_id)) else $error("hold");
	a_idle_clear: assert property (!active |-> slot_used == 10'h000) else $error("idle");
endmodule // apm_poll_monitor
bind apm_poll_manager apm_poll_monitor i_apm_poll_monitor (.*);

// ### sim/apm_panel_model.sv
// Purpose: panel side answering fetches
// Assumes: one fetch in flight
// Notes: ready every other cycle, value from id
`timescale 1ns/1ps
module apm_panel_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_id,
	output logic fetch_ready,
	output logic fetch_done,
	output logic [15:0] fetch_value
);
	// ====================
	// slow ready, result a cycle after taking, junk when idle
	logic tick_reg;
	assign fetch_ready = tick_reg;
	always_ff @(posedge clk) begin
		tick_reg <= rst_b & ~tick_reg;
		fetch_done <= rst_b & fetch_valid & tick_reg;
		fetch_value <= !rst_b ? 16'h0000 : (fetch_valid & tick_reg) ? fetch_id ^ 16'h5A5A : ~fetch_value;
	end
endmodule // apm_panel_model

// ### sim/testbench.sv
// Purpose: self-checking bench of the poll manager
// Assumes: short refresh and idle counts
// Notes: panel model answers fetches
`timescale 1ns/1ps
module testbench;
	import apm_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic req_valid = 1'b0;
	logic [4:0] req_count = 5'h00;
	logic [159:0] req_ids = 160'h0;
	logic [9:0] req_is_loop = 10'h000;
	logic [9:0] point_alarm = 10'h000;
	logic rsp_valid, fetch_valid, fetch_ready, fetch_done, active;
	logic [1:0] rsp_code;
	logic [159:0] rsp_values;
	logic [15:0] fetch_id, fetch_value;
	logic [9:0] slot_used;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_fetch = 0;
	apm_poll_manager #(.REFRESH_CYC(50), .IDLE_CYC(300)) i_apm_poll_manager (
		.clk(clk),
		.rst_b(rst_b),
		.req_valid(req_valid),
		.req_count(req_count),
		.req_ids(req_ids),
		.req_is_loop(req_is_loop),
		.point_alarm(point_alarm),
		.rsp_valid(rsp_valid),
		.rsp_code(rsp_code),
		.rsp_values(rsp_values),
		.fetch_valid(fetch_valid),
		.fetch_id(fetch_id),
		.fetch_ready(fetch_ready),
		.fetch_done(fetch_done),
		.fetch_value(fetch_value),
		.active(active),
		.slot_used(slot_used)
	);
	apm_panel_model i_apm_panel_model (
		.clk(clk),
		.rst_b(rst_b),
		.fetch_valid(fetch_valid),
		.fetch_id(fetch_id),
		.fetch_ready(fetch_ready),
		.fetch_done(fetch_done),
		.fetch_value(fetch_value)
	);
	// ====================
	// clock, fetch count, hang guard
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		n_fetch += int'(fetch_valid && fetch_ready);
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [159:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one request, answer looked at while it stands, half a cycle after the take
	task automatic req(input logic [4:0] n, input logic [15:0] a, b, input logic [9:0] lp, input logic [1:0] code);
		@(negedge clk);
		req_valid = 1'b1;
		req_count = n;
		req_ids = {128'h0, b, a};
		req_is_loop = lp;
		@(negedge clk);
		req_valid = 1'b0;
		chk("rsp_valid", rsp_valid, 1'b1);
		chk("rsp_code", rsp_code, code);
	endtask
	task automatic t_refuse;
		req(5'h0B, 16'h0001, 16'h0002, 10'h3FF, APM_RSP_EXC_COUNT);
		chk("active", active, 1'b0);
		req(5'h00, 16'h0001, 16'h0002, 10'h3FF, APM_RSP_EXC_COUNT);
		req(5'h02, 16'h0001, 16'h0002, 10'h3FE, APM_RSP_EXC_TYPE);
		chk("active", active, 1'b0);
		$display("t_refuse done");
	endtask
	task automatic t_init;
		point_alarm = 10'h001;
		req(5'h02, 16'h0001, 16'h0002, 10'h3FF, APM_RSP_INIT);
		chk("zeros", rsp_values, 160'h0);
		repeat (40) @(negedge clk);
		chk("early", n_fetch, 0);
		repeat (35) @(negedge clk);
		req(5'h02, 16'h0001, 16'h0002, 10'h3FF, APM_RSP_VALUES);
		chk("vals", rsp_values, 160'h5A5B);
		chk("fetches", n_fetch, 1);
		point_alarm = 10'h000;
		repeat (60) @(negedge clk);
		req(5'h02, 16'h0001, 16'h0002, 10'h3FF, APM_RSP_VALUES);
		chk("cleared", rsp_values, 160'h0);
		$display("t_init done");
	endtask
	task automatic t_overlap;
		point_alarm = 10'h001;
		repeat (60) @(negedge clk);
		req(5'h02, 16'h0001, 16'h0005, 10'h3FF, APM_RSP_INIT);
		chk("kept", rsp_values, 160'h5A5B);
		chk("slots", slot_used, 10'h003);
		point_alarm = 10'h000;
		$display("t_overlap done");
	endtask
	task automatic t_idle;
		repeat (200) @(negedge clk);
		req(5'h02, 16'h0001, 16'h0005, 10'h3FF, APM_RSP_VALUES);
		repeat (200) @(negedge clk);
		chk("kept alive", active, 1'b1);
		repeat (120) @(negedge clk);
		chk("expired", {active, slot_used}, 11'h000);
		$display("t_idle done");
	endtask
	task automatic finish_test;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		t_refuse();
		t_init();
		t_overlap();
		t_idle();
		finish_test();
	end
endmodule // testbench
